// ---- rtl/crrc_pkg.sv ----
/*
  Package for the configuration readback and reprogram controller: option encodings, frame layout,
  timing counts and the state type of the device end.
  Assumes both ends and the testbench import it.
*/
package crrc_pkg;

  // Readback permission set by the configuration options.
  typedef enum logic [1:0] {
    CRRC_RB_NEVER   = 2'b00,
    CRRC_RB_ONCE    = 2'b01,
    CRRC_RB_COMMAND = 2'b10
  } crrc_rb_perm_e;

  // Device end state machine.
  typedef enum logic [2:0] {
    CRRC_ST_CLEAR  = 3'b000,
    CRRC_ST_CONFIG = 3'b001,
    CRRC_ST_START  = 3'b010,
    CRRC_ST_RUN    = 3'b011
  } crrc_state_e;

  // Readback frame layout.
  localparam int unsigned CRRC_DUMMY_BITS  = 2;
  localparam int unsigned CRRC_FRAME_DATA  = 8;
  localparam int unsigned CRRC_FRAME_COUNT = 4;
  localparam int unsigned CRRC_FRAME_BITS  = CRRC_FRAME_DATA + 2;
  localparam int unsigned CRRC_RB_BITS     = CRRC_DUMMY_BITS + CRRC_FRAME_BITS * CRRC_FRAME_COUNT;
  localparam int unsigned CRRC_CFG_BITS    = CRRC_FRAME_DATA * CRRC_FRAME_COUNT;
  localparam int unsigned CRRC_STORE_BITS  = 4;
  localparam int unsigned CRRC_USER_IO     = 8;
  localparam logic        CRRC_START_BIT   = 1'b0;
  localparam logic        CRRC_STOP_BIT    = 1'b1;
  // Trigger pin flip-flops, and link rises from trigger to first stream bit at the controller.
  localparam int unsigned CRRC_TRIG_SYNC   = 2;
  localparam int unsigned CRRC_RB_LEAD     = CRRC_TRIG_SYNC + 2;

  // Reprogram filter length in timing generator ticks.
  localparam logic [1:0]  CRRC_FILTER_TICKS = 2'h2;
  // Memory clear length in timing generator ticks.
  localparam logic [7:0]  CRRC_CLEAR_TICKS  = 8'h10;
  // Link clock divider of the host end: half period in system cycles.
  localparam logic [3:0]  CRRC_HOST_HALF    = 4'h2;

endpackage : crrc_pkg

// ---- rtl/crrc_link_if.sv ----
/*
  Interface joining the device end and the external controller end.
  Assumes the bench resolves the open-drain done/program pin from both enables.
*/
`timescale 1ns/100ps
interface crrc_link_if;
  logic config_clock;
  logic readback_trigger;
  logic mode_select_one_in;
  logic readback_data_out;
  logic readback_data_oe;
  logic done_program_pin;
  logic done_drive_low_dev;
  logic done_pullup_en;
  logic done_drive_low_host;
  logic init_complete_indication;

  modport device (
    input  config_clock, readback_trigger, mode_select_one_in, done_program_pin,
    output readback_data_out, readback_data_oe, done_drive_low_dev, done_pullup_en,
    output init_complete_indication
  );
  modport host (
    output config_clock, readback_trigger, mode_select_one_in, done_drive_low_host,
    input  readback_data_out, readback_data_oe, done_program_pin, init_complete_indication
  );
endinterface : crrc_link_if

// ---- rtl/crrc_device.sv ----
/*
  Device end: readback, reprogram filtering, start-up timing, pull-up and oscillator division.
  Assumes config_clock comes from the controller; osc_clk is the crystal clock on nrst.
*/
`timescale 1ns/100ps
module crrc_device
  import crrc_pkg::*;
(
  // System
  input  wire logic                      osc_clk,
  input  wire logic                      nrst,
  // Link
  crrc_link_if.device                    link,
  // Configuration loading results
  input  wire logic                      cfg_done_load,
  input  wire logic [CRRC_CFG_BITS-1:0]  cfg_memory,
  input  wire logic [1:0]                opt_readback,
  input  wire logic                      opt_done_pullup,
  input  wire logic                      opt_done_early,
  input  wire logic                      opt_reset_early,
  input  wire logic                      opt_osc_div2,
  input  wire logic [CRRC_USER_IO-1:0]   opt_io_pullup,
  // User logic state
  input  wire logic [CRRC_STORE_BITS-1:0] store_state,
  // User side outputs
  output logic                           cfg_clear_req,
  output logic                           user_out_enable,
  output logic                           user_reset,
  output logic [CRRC_USER_IO-1:0]        io_pullup_en,
  output logic                           timing_tick,
  output logic                           readback_busy,
  output logic                           readback_locked
);

  ////////////////////////////////////////////////////////////////////////////
  // Timing generator.
  logic div_q;
  logic tick;
  assign tick        = opt_osc_div2 ? div_q : 1'b1;
  assign timing_tick = tick;
  always_ff @(posedge osc_clk or negedge nrst) begin
    if (!nrst) div_q <= 1'b0;
    else div_q <= ~div_q;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Done pin synchroniser and reprogram filter.
  logic       dp_s1_q;
  logic       dp_s2_q;
  logic [1:0] filt_q;
  logic       reprog_req;
  always_ff @(posedge osc_clk or negedge nrst) begin
    if (!nrst) begin
      dp_s1_q <= 1'b1;
      dp_s2_q <= 1'b1;
    end else begin
      dp_s1_q <= link.done_program_pin;
      dp_s2_q <= dp_s1_q;
    end
  end

  crrc_state_e st_q;
  logic [7:0]  clr_q;
  logic [1:0]  su_q;
  always_ff @(posedge osc_clk or negedge nrst) begin
    if (!nrst) filt_q <= 2'h0;
    else if (dp_s2_q || st_q != CRRC_ST_RUN) filt_q <= 2'h0;
    else if (tick && filt_q != CRRC_FILTER_TICKS) filt_q <= filt_q + 2'h1;
  end
  assign reprog_req = (filt_q == CRRC_FILTER_TICKS);

  ////////////////////////////////////////////////////////////////////////////
  // Configuration sequence.
  logic cfg_done_q;
  always_ff @(posedge osc_clk or negedge nrst) begin
    if (!nrst) begin
      st_q <= CRRC_ST_CLEAR;
      clr_q <= 8'h00;
      su_q <= 2'h0;
    end else begin
      case (st_q)
        CRRC_ST_CLEAR: begin
          if (tick) clr_q <= clr_q + 8'h01;
          if (clr_q == CRRC_CLEAR_TICKS) st_q <= CRRC_ST_CONFIG;
        end
        CRRC_ST_CONFIG: begin
          su_q <= 2'h0;
          if (cfg_done_load) st_q <= CRRC_ST_START;
        end
        CRRC_ST_START: begin
          su_q <= su_q + 2'h1;
          if (su_q == 2'h2) st_q <= CRRC_ST_RUN;
        end
        CRRC_ST_RUN: begin
          clr_q <= 8'h00;
          if (reprog_req) st_q <= CRRC_ST_CLEAR;
        end
        default: st_q <= CRRC_ST_CLEAR;
      endcase
    end
  end
  assign cfg_done_q    = (st_q == CRRC_ST_RUN);
  assign cfg_clear_req = (st_q == CRRC_ST_CLEAR);
  assign link.init_complete_indication = (st_q != CRRC_ST_CLEAR);

  // Start-up: outputs at step 1, done/reset at step 0 or 2.
  logic in_start;
  logic outs_on;
  logic done_on;
  logic reset_off;
  assign in_start = (st_q == CRRC_ST_START);
  assign outs_on  = cfg_done_q || (in_start && su_q >= 2'h1);
  assign done_on  = cfg_done_q || (in_start && (opt_done_early ? 1'b1 : su_q >= 2'h2));
  assign reset_off = cfg_done_q || (in_start && (opt_reset_early ? 1'b1 : su_q >= 2'h2));
  assign user_out_enable = outs_on;
  assign user_reset = ~reset_off;
  assign link.done_drive_low_dev = ~done_on;
  assign link.done_pullup_en     = opt_done_pullup;
  assign io_pullup_en = outs_on ? opt_io_pullup : {CRRC_USER_IO{1'b1}};

  ////////////////////////////////////////////////////////////////////////////
  // Crossing into the link clock domain.
  logic run_l1_q;
  logic run_l2_q;
  logic perm_once;
  logic perm_cmd;
  always_ff @(posedge link.config_clock or negedge nrst) begin
    if (!nrst) begin
      run_l1_q <= 1'b0;
      run_l2_q <= 1'b0;
    end else begin
      run_l1_q <= cfg_done_q;
      run_l2_q <= run_l1_q;
    end
  end
  assign perm_once = (opt_readback == CRRC_RB_ONCE);
  assign perm_cmd  = (opt_readback == CRRC_RB_COMMAND);

  ////////////////////////////////////////////////////////////////////////////
  // Readback engine on the link clock.
  logic                     trg_s1_q;
  logic                     trg_s2_q;
  logic                     trg_q;
  logic                     oe_q;
  logic                     busy_q;
  logic                     lock_q;
  logic [5:0]               bit_q;
  logic                     rd_q;
  logic [CRRC_CFG_BITS-1:0] snap_q;
  logic                     start_rb;
  logic [5:0]               pos;
  logic [3:0]               fpos;
  logic [5:0]               fidx;
  logic                     next_bit;

  assign start_rb = trg_s2_q && !trg_q && !busy_q && run_l2_q &&
                    (perm_cmd || (perm_once && !lock_q));
  assign pos  = bit_q - 6'(CRRC_DUMMY_BITS);
  assign fpos = 4'(pos % 6'(CRRC_FRAME_BITS));
  assign fidx = 6'((pos / 6'(CRRC_FRAME_BITS)) * 6'(CRRC_FRAME_DATA)) + 6'(fpos) - 6'h01;
  assign next_bit = (bit_q < 6'(CRRC_DUMMY_BITS)) ? 1'b1 :
                    (fpos == 4'h0) ? CRRC_START_BIT :
                    (fpos == 4'(CRRC_FRAME_BITS - 1)) ? CRRC_STOP_BIT : ~snap_q[fidx[4:0]];

  always_ff @(posedge link.config_clock or negedge nrst) begin
    if (!nrst) begin
      trg_s1_q <= 1'b0;
      trg_s2_q <= 1'b0;
      trg_q <= 1'b0;
      oe_q <= 1'b0;
      busy_q <= 1'b0;
      lock_q <= 1'b0;
      bit_q <= 6'h00;
      rd_q <= 1'b1;
      snap_q <= '0;
    end else begin
      // Trigger pin passes two flip-flops before the edge detector.
      trg_s1_q <= link.readback_trigger;
      trg_s2_q <= trg_s1_q;
      trg_q    <= trg_s2_q;
      // Enable trails busy by one rise so it frames exactly the shifted bits.
      oe_q     <= busy_q;
      if (!run_l2_q) lock_q <= 1'b0;
      if (start_rb) begin
        busy_q <= 1'b1;
        bit_q <= 6'h00;
        snap_q <= {cfg_memory[CRRC_CFG_BITS-1:CRRC_STORE_BITS], store_state};
      end else if (busy_q) begin
        rd_q <= next_bit;
        bit_q <= bit_q + 6'h01;
        if (bit_q == 6'(CRRC_RB_BITS - 1)) begin
          busy_q <= 1'b0;
          lock_q <= perm_once;
        end
      end
    end
  end
  // Only readback_data_out carries data; the mode select input is not used.
  assign link.readback_data_out = rd_q;
  assign link.readback_data_oe  = oe_q;
  assign readback_busy   = busy_q;
  assign readback_locked = lock_q;

endmodule : crrc_device

// ---- rtl/crrc_host.sv ----
/*
  Controller end: makes the link clock, issues readback triggers, collects frames and requests
  reprogramming on the done pin.
  Assumes the bench resolves the done pin; this end runs on clk.
*/
`timescale 1ns/100ps
module crrc_host
  import crrc_pkg::*;
(
  // System
  input  wire logic                     clk,
  input  wire logic                     nrst,
  // Link
  crrc_link_if.host                     link,
  // User requests
  input  wire logic                     rb_start,
  input  wire logic                     reprog_start,
  // User results
  output logic                          rb_busy,
  output logic                          rb_valid,
  output logic [CRRC_RB_BITS-1:0]       rb_data,
  output logic                          done_seen,
  output logic                          init_seen
);

  ////////////////////////////////////////////////////////////////////////////
  // Link clock divider.
  logic [3:0] div_q;
  logic       cc_q;
  logic       rise;
  logic       fall;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      div_q <= 4'h0;
      cc_q <= 1'b0;
    end else if (div_q == CRRC_HOST_HALF - 4'h1) begin
      div_q <= 4'h0;
      cc_q <= ~cc_q;
    end else div_q <= div_q + 4'h1;
  end
  assign rise = (div_q == CRRC_HOST_HALF - 4'h1) && !cc_q;
  assign fall = (div_q == CRRC_HOST_HALF - 4'h1) && cc_q;
  assign link.config_clock = cc_q;

  ////////////////////////////////////////////////////////////////////////////
  // Readback sequence.
  logic       trg_q;
  logic [6:0] cnt_q;
  logic [CRRC_RB_BITS-1:0] sh_q;
  logic       valid_q;
  logic       busy_q;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      trg_q <= 1'b0;
      cnt_q <= 7'h00;
      sh_q <= '0;
      valid_q <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      valid_q <= 1'b0;
      if (rb_start && !busy_q) begin
        busy_q <= 1'b1;
        cnt_q <= 7'h00;
      end else if (busy_q && !trg_q && fall) begin
        trg_q <= 1'b1;
      end else if (trg_q && rise) begin
        cnt_q <= cnt_q + 7'h01;
        if (cnt_q >= 7'(CRRC_RB_LEAD)) sh_q <= {sh_q[CRRC_RB_BITS-2:0], link.readback_data_out};
        if (cnt_q == 7'(CRRC_RB_LEAD + CRRC_RB_BITS - 1)) begin
          busy_q <= 1'b0;
          trg_q <= 1'b0;
          valid_q <= 1'b1;
        end
      end
    end
  end
  assign link.readback_trigger   = trg_q;
  assign link.mode_select_one_in = 1'b0;
  assign rb_busy  = busy_q;
  assign rb_valid = valid_q;
  assign rb_data  = sh_q;

  ////////////////////////////////////////////////////////////////////////////
  // Reprogram pulse and pin watch.
  logic [3:0] rp_q;
  logic d1_q;
  logic d2_q;
  logic i1_q;
  logic i2_q;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) rp_q <= 4'h0;
    else if (reprog_start) rp_q <= 4'hf;
    else if (rp_q != 4'h0) rp_q <= rp_q - 4'h1;
  end
  assign link.done_drive_low_host = (rp_q != 4'h0);
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      d1_q <= 1'b0;
      d2_q <= 1'b0;
      i1_q <= 1'b0;
      i2_q <= 1'b0;
    end else begin
      d1_q <= link.done_program_pin;
      d2_q <= d1_q;
      i1_q <= link.init_complete_indication;
      i2_q <= i1_q;
    end
  end
  assign done_seen = d2_q;
  assign init_seen = i2_q;

endmodule : crrc_host

// ---- testbench/crrc_link_assertions.sv ----
/*
  Checker of the link between the device end and the controller end.
  Assumes the bench instantiates it beside the interface and hands it the link signals.
*/
`timescale 1ns/100ps
module crrc_link_assertions (
  // Clocks and reset
  input wire logic osc_clk,
  input wire logic nrst,
  input wire logic config_clock,
  // Link signals
  input wire logic readback_trigger,
  input wire logic readback_data_out,
  input wire logic readback_data_oe,
  input wire logic done_drive_low_dev,
  input wire logic done_drive_low_host,
  input wire logic init_complete_indication
);
  ////////////////////////////////////////////////////////////////////////////////
  property p_clear_hold;
    @(posedge osc_clk) disable iff (!nrst) !init_complete_indication |-> done_drive_low_dev;
  endproperty
  a_clear_hold: assert property (p_clear_hold)
    else $error("done pin released while clearing");
  property p_init_len;
    @(posedge osc_clk) disable iff (!nrst) $fell(init_complete_indication) |-> !init_complete_indication[*8];
  endproperty
  a_init_len: assert property (p_init_len)
    else $error("init indication returned too early");
  property p_reprog_hold;
    @(posedge osc_clk) disable iff (!nrst)
      $rose(done_drive_low_host) ##1 done_drive_low_host[*7] |-> ##[0:40] done_drive_low_dev;
  endproperty
  a_reprog_hold: assert property (p_reprog_hold)
    else $error("device did not hold the done pin low");
  ////////////////////////////////////////////////////////////////////////////////
  property p_dummy;
    @(posedge config_clock) disable iff (!nrst)
      $rose(readback_data_oe) |-> readback_data_out ##1 readback_data_out ##1 !readback_data_out;
  endproperty
  a_dummy: assert property (p_dummy)
    else $error("dummy bits or first start bit wrong");
  property p_frame_stop;
    @(posedge config_clock) disable iff (!nrst)
      $rose(readback_data_oe) |-> ##11 readback_data_out ##1 !readback_data_out;
  endproperty
  a_frame_stop: assert property (p_frame_stop)
    else $error("first frame not closed by one stop bit");
  property p_oe_span;
    @(posedge config_clock) disable iff (!nrst)
      $rose(readback_data_oe) |-> readback_data_oe[*8] ##34 readback_data_oe ##1 !readback_data_oe;
  endproperty
  a_oe_span: assert property (p_oe_span)
    else $error("readback did not span all frames");
  property p_trigger;
    @(posedge config_clock) disable iff (!nrst)
      $rose(readback_data_oe) |-> $past(readback_trigger) || $past(readback_trigger, 2);
  endproperty
  a_trigger: assert property (p_trigger)
    else $error("readback started without trigger");
  property p_last_stop;
    @(posedge config_clock) disable iff (!nrst) $fell(readback_data_oe) |-> $past(readback_data_out);
  endproperty
  a_last_stop: assert property (p_last_stop)
    else $error("last frame not closed by stop bit");
endmodule : crrc_link_assertions

// ---- testbench/config_readback_reprogram_ctrl_test.sv ----
/*
  Testbench joining both ends through the link interface.
  Assumes an external pull-up on the done pin; the device shares the bench clock as crystal clock.
*/
`timescale 1ns/100ps
module config_readback_reprogram_ctrl_test;
  import crrc_pkg::*;
  logic                       clk, nrst, cfg_done_load, opt_done_pullup, opt_done_early, opt_reset_early;
  logic                       opt_osc_div2, rb_start, reprog_start, oe_seen;
  logic [CRRC_CFG_BITS-1:0]   cfg_memory;
  logic [1:0]                 opt_readback;
  logic [CRRC_USER_IO-1:0]    opt_io_pullup, io_pullup_en;
  logic [CRRC_STORE_BITS-1:0] store_state;
  logic                       cfg_clear_req, user_out_enable, user_reset, timing_tick, readback_busy;
  logic                       readback_locked, rb_busy, rb_valid, done_seen, init_seen;
  logic [CRRC_RB_BITS-1:0]    rb_data;
  int                         fails, total_checks, n0, n1;

  crrc_link_if link ();
  assign link.done_program_pin = (link.done_drive_low_dev || link.done_drive_low_host) ? 1'b0 : 1'b1;

  crrc_device crrc_device_i (.osc_clk(clk), .nrst(nrst), .link(link), .cfg_done_load(cfg_done_load),
    .cfg_memory(cfg_memory), .opt_readback(opt_readback), .opt_done_pullup(opt_done_pullup),
    .opt_done_early(opt_done_early), .opt_reset_early(opt_reset_early), .opt_osc_div2(opt_osc_div2),
    .opt_io_pullup(opt_io_pullup), .store_state(store_state), .cfg_clear_req(cfg_clear_req),
    .user_out_enable(user_out_enable), .user_reset(user_reset), .io_pullup_en(io_pullup_en),
    .timing_tick(timing_tick), .readback_busy(readback_busy), .readback_locked(readback_locked));
  crrc_host crrc_host_i (.clk(clk), .nrst(nrst), .link(link), .rb_start(rb_start), .reprog_start(reprog_start),
    .rb_busy(rb_busy), .rb_valid(rb_valid), .rb_data(rb_data), .done_seen(done_seen), .init_seen(init_seen));
  crrc_link_assertions crrc_link_assertions_i (.osc_clk(clk), .nrst(nrst), .config_clock(link.config_clock),
    .readback_trigger(link.readback_trigger), .readback_data_out(link.readback_data_out),
    .readback_data_oe(link.readback_data_oe), .done_drive_low_dev(link.done_drive_low_dev),
    .done_drive_low_host(link.done_drive_low_host), .init_complete_indication(link.init_complete_indication));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [63:0] got, input logic [63:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check

  task automatic wait_for(ref logic sig, input logic lvl, input int limit, input string what);
    int n;
    n = 0;
    while (sig !== lvl && n < limit) begin
      @(posedge clk);
      #1;
      n++;
    end
    check(n < limit, 1'b1, what);
  endtask : wait_for

  function automatic logic [CRRC_RB_BITS-1:0] rb_expect(input logic [CRRC_CFG_BITS-1:0] mem,
                                                        input logic [CRRC_STORE_BITS-1:0] st);
    logic [CRRC_CFG_BITS-1:0] snap;
    logic [CRRC_RB_BITS-1:0]  s;
    int                       m;
    snap = {mem[CRRC_CFG_BITS-1:CRRC_STORE_BITS], st};
    s = '1;
    for (int n = CRRC_DUMMY_BITS; n < CRRC_RB_BITS; n++) begin
      m = (n - CRRC_DUMMY_BITS) % CRRC_FRAME_BITS;
      if (m == 0) s[CRRC_RB_BITS-1-n] = CRRC_START_BIT;
      else if (m < CRRC_FRAME_BITS - 1)
        s[CRRC_RB_BITS-1-n] = ~snap[(n - CRRC_DUMMY_BITS) / CRRC_FRAME_BITS * CRRC_FRAME_DATA + m - 1];
    end
    return s;
  endfunction : rb_expect

  task automatic configure(input logic de, input logic re);
    int t_out, t_done, t_rst;
    #1;
    check({user_out_enable, user_reset, io_pullup_en}, {2'b01, 8'hff}, "clearing state");
    wait_for(cfg_clear_req, 1'b0, 400, "clear ends");
    repeat (4) @(posedge clk);
    check({link.init_complete_indication, init_seen}, 2'b11, "init after clear");
    @(posedge clk) cfg_done_load <= 1'b1;
    t_out = -1;
    t_done = -1;
    t_rst = -1;
    for (int c = 0; c < 40; c++) begin
      @(posedge clk);
      #1;
      if (t_out < 0 && user_out_enable === 1'b1) t_out = c;
      if (t_done < 0 && link.done_drive_low_dev === 1'b0) t_done = c;
      if (t_rst < 0 && user_reset === 1'b0) t_rst = c;
    end
    check(t_done - t_out + 2, de ? 1 : 3, "done timing");
    check(t_rst - t_out + 2, re ? 1 : 3, "reset timing");
    check({io_pullup_en, link.done_pullup_en, done_seen}, {opt_io_pullup, opt_done_pullup, 1'b1}, "run");
  endtask : configure

  task automatic reprogram(input logic de, input logic re);
    @(posedge clk);
    cfg_done_load <= 1'b0;
    reprog_start <= 1'b1;
    opt_done_early <= de;
    opt_reset_early <= re;
    opt_done_pullup <= 1'($urandom);
    cfg_memory <= $urandom;
    @(posedge clk) reprog_start <= 1'b0;
    wait_for(cfg_clear_req, 1'b1, 200, "reprogram accepted");
    configure(de, re);
    check(readback_locked, 1'b0, "lock cleared");
    $display("test reprogram finished");
  endtask : reprogram

  task automatic readback(input logic ok);
    @(posedge clk) store_state <= CRRC_STORE_BITS'($urandom);
    oe_seen = 1'b0;
    @(posedge clk) rb_start <= 1'b1;
    @(posedge clk) rb_start <= 1'b0;
    #1;
    check(rb_busy, 1'b1, "controller busy");
    if (ok) begin
      wait_for(rb_valid, 1'b1, 600, "readback done");
      check(rb_data, rb_expect(cfg_memory, store_state), "readback stream");
      check({rb_busy, readback_busy}, 2'b00, "readback idle");
      repeat (16) @(posedge clk);
    end else begin
      repeat (600) @(posedge clk);
      check({oe_seen, readback_busy}, 2'b00, "refused readback");
    end
    $display("test readback finished");
  endtask : readback

  task automatic count_ticks(output int n);
    n = 0;
    repeat (64) begin
      @(posedge clk);
      #1;
      if (timing_tick === 1'b1) n++;
    end
  endtask : count_ticks

  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : summarize

  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge clk) if (link.readback_data_oe === 1'b1) oe_seen = 1'b1;

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  initial begin
    #(40 * 30000);
    fails++;
    $display("mismatch at %0t: watchdog expired", $time);
    summarize();
  end

  initial begin
    void'($urandom(23456));
    {nrst, cfg_done_load, opt_done_early, opt_reset_early, opt_osc_div2, rb_start, reprog_start} = '0;
    opt_done_pullup = 1'b1;
    oe_seen = 1'b0;
    cfg_memory = $urandom;
    opt_io_pullup = CRRC_USER_IO'($urandom);
    store_state = CRRC_STORE_BITS'($urandom);
    opt_readback = CRRC_RB_COMMAND;
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    configure(1'b0, 1'b0);
    $display("test configure finished");
    readback(1'b1);
    readback(1'b1);
    check(readback_locked, 1'b0, "command mode unlocked");
    @(posedge clk) opt_readback <= CRRC_RB_NEVER;
    readback(1'b0);
    @(posedge clk) opt_readback <= CRRC_RB_ONCE;
    readback(1'b1);
    check(readback_locked, 1'b1, "once mode locked");
    readback(1'b0);
    reprogram(1'b0, 1'b1);
    readback(1'b1);
    count_ticks(n0);
    @(posedge clk) opt_osc_div2 <= 1'b1;
    reprogram(1'b1, 1'b0);
    count_ticks(n1);
    check(n1 > 0 && n0 >= 2 * n1 - 2 && n0 <= 2 * n1 + 2, 1'b1, "timing tick halved");
    reprogram(1'b1, 1'b1);
    @(posedge clk) opt_readback <= CRRC_RB_COMMAND;
    readback(1'b1);
    summarize();
  end
endmodule : config_readback_reprogram_ctrl_test
